// ===== core/i2c_tx_channel.sv
// Simple I2C master transmit channel with an Avalon-MM register slave.
module i2c_tx_channel
  import i2c_tx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);

  // What this block does
  // - After start, address byte goes out as one frame: seven address bits, direction LSB.
  // - Each finished frame raises a transfer end event, plus ack error on a nack; buffer-empty type is refused.
  // - A missing acknowledge sets the ack error flag at parity error position.
  // - Bit rate at most a quarter of operation clock; divisor must be one or more.
  // - Data driven non-inverted, idling high; no parity.
  // - Bytes go MSB first, then one slot where acknowledge is sampled.
  // - Clock select bit chooses prescaler clock zero or one.
  // - Only the low data byte is the buffer; upper bits keep the divisor.
  // - Data bytes follow the address; software then makes stop and frees the bus.
  // - Address, data send and stop are the supported operations; there is no data receive path.
  // - Single master only: no slave mode, arbitration or wait detection.

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [15:0]     mode_q, mode_d;
  logic [15:0]     comm_q, comm_d;
  logic [15:0]     data_q, data_d;
  logic [1:0]      lvl_q, lvl_d;         // bit 1 SCL level, bit 0 SDA level
  logic            oen_q, oen_d;         // serial_output_enable_bit
  logic            go_q, go_d;           // channel_start_bit
  logic [ST_W-1:0] stat_q, stat_d;
  logic [ST_W-1:0] mask_q, mask_d;
  logic [31:0]     rdata_q, rdata_d;
  logic            wait_q, wait_d;
  logic            irq_q, irq_d;

  // Shifter state.
  tx_state_t       st_q, st_d;
  logic [3:0]      bit_q, bit_d;
  logic [7:0]      shf_q, shf_d;
  logic [7:0]      pre_q, pre_d;
  logic [6:0]      div_q, div_d;
  logic            sda_bit_q, sda_bit_d;
  logic            scl_drv_q, scl_drv_d;
  logic            ack_err_q, ack_err_d;
  logic            ev_end, ev_ack, ev_bad;
  i2c_pins_t       pins_q, pins_d;

  logic            acc, take, tick, busy;

  // Reads fetch at the first edge so data stands when waitrequest is low; writes land then.
  assign take = (avs_read | avs_write) & wait_q;
  assign acc  = (avs_read | avs_write) & ~wait_q;
  assign busy = (st_q != S_IDLE);

  // ------------------------------------------------------------------
  // Operation clock prescaler
  // ------------------------------------------------------------------
  // The selected prescaler output is a one-cycle tick that paces the shifter.
  always_comb
  begin
    pre_d = pre_q + 8'h01;
    tick  = 1'b0;
    if (pre_q >= (mode_q[MODE_CKS_BIT] ? PRE1_DIV : PRE0_DIV))
    begin
      pre_d = 8'h00;
      tick  = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Frame shifter
  // ------------------------------------------------------------------
  // SCL only toggles inside a frame; between frames the software levels own the lines.
  always_comb
  begin
    st_d      = st_q;
    bit_d     = bit_q;
    shf_d     = shf_q;
    div_d     = div_q;
    sda_bit_d = sda_bit_q;
    scl_drv_d = scl_drv_q;
    ack_err_d = ack_err_q;
    ev_end    = 1'b0;
    ev_ack    = 1'b0;
    ev_bad    = 1'b0;
    // Half period is divisor plus one ticks, so a divisor of one gives a quarter rate.
    if (tick && busy)
      div_d = (div_q < DIV_MIN) ? data_q[DIV_HI:DIV_LO] : div_q - 7'h01;
    case (st_q)
      S_IDLE:
      begin
        scl_drv_d = 1'b1;
        if (go_q)
        begin
          // A zero divisor or buffer-empty interrupt type is refused outright.
          if (data_q[DIV_HI:DIV_LO] < DIV_MIN || mode_q[MODE_INTSEL_BIT])
            ev_bad = 1'b1;
          else
          begin
            shf_d     = data_q[7:0];
            bit_d     = 4'h0;
            div_d     = data_q[DIV_HI:DIV_LO];
            scl_drv_d = 1'b0;
            sda_bit_d = data_q[7];
            ack_err_d = 1'b0;
            st_d      = S_LOW;
          end
        end
      end
      S_LOW:
        if (tick && div_q < DIV_MIN)
        begin
          scl_drv_d = 1'b1;
          st_d      = S_HIGH;
        end
      S_HIGH:
        if (tick && div_q < DIV_MIN)
        begin
          if (bit_q == BIT_LAST)
          begin
            // Ninth clock ends: a high data line means no acknowledge.
            ack_err_d = sda_i;
            st_d      = S_DONE;
          end
          else
          begin
            bit_d     = bit_q + 4'h1;
            shf_d     = {shf_q[6:0], 1'b0};
            // Release SDA for the acknowledge slot after eight bits.
            sda_bit_d = (bit_q == BIT_LAST - 4'h1) ? 1'b1 : shf_q[6];
            scl_drv_d = 1'b0;
            st_d      = S_LOW;
          end
        end
      S_DONE:
      begin
        ev_end = 1'b1;
        ev_ack = ack_err_q;
        st_d   = S_IDLE;
      end
      default:
        st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q      <= S_IDLE;
      bit_q     <= 4'h0;
      shf_q     <= 8'h00;
      pre_q     <= 8'h00;
      div_q     <= 7'h00;
      sda_bit_q <= 1'b1;
      scl_drv_q <= 1'b1;
      ack_err_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      bit_q     <= bit_d;
      shf_q     <= shf_d;
      pre_q     <= pre_d;
      div_q     <= div_d;
      sda_bit_q <= sda_bit_d;
      scl_drv_q <= scl_drv_d;
      ack_err_q <= ack_err_d;
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  // Open drain: lines are only pulled low; SCL is read back only into the busy register, so no wait detection.
  always_comb
  begin
    pins_d.scl_o  = 1'b0;
    pins_d.sda_o  = 1'b0;
    pins_d.scl_oe = busy ? ~scl_drv_d : ~lvl_d[1];
    // Enable hands SDA to the shifter; while it is low the level register makes start and stop.
    pins_d.sda_oe = (busy & oen_d) ? ~sda_bit_d : ~lvl_d[0];
  end

  // ------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------
  // Every access waits one cycle, so read data and waitrequest leave flops.
  always_comb
  begin
    mode_d  = mode_q;
    comm_d  = comm_q;
    data_d  = data_q;
    lvl_d   = lvl_q;
    oen_d   = oen_q;
    go_d    = go_q & ~(st_q == S_IDLE);        // start bit falls once taken
    mask_d  = mask_q;
    rdata_d = rdata_q;
    wait_d  = ~take;
    stat_d  = stat_q;
    if (acc && avs_write)
    begin
      if (avs_address == OFS_MODE)
        mode_d = avs_writedata[15:0];
      else if (avs_address == OFS_COMM)
        comm_d = avs_writedata[15:0];
      else if (avs_address == OFS_DATA)
        data_d = busy ? {data_q[15:8], avs_writedata[7:0]} : avs_writedata[15:0];
      else if (avs_address == OFS_OUTLVL)
        lvl_d = avs_writedata[1:0];
      else if (avs_address == OFS_OUTEN)
        oen_d = avs_writedata[0];
      else if (avs_address == OFS_START)
        go_d = avs_writedata[0];
      else if (avs_address == OFS_STATUS)
        stat_d = stat_q & ~avs_writedata[ST_W-1:0];
      else if (avs_address == OFS_MASK)
        mask_d = avs_writedata[ST_W-1:0];
    end
    // Events set after the clear so a same-cycle event survives.
    stat_d[ST_END_BIT]    = stat_d[ST_END_BIT] | ev_end;
    stat_d[ST_ACKERR_BIT] = stat_d[ST_ACKERR_BIT] | ev_ack;
    stat_d[ST_BADCFG_BIT] = stat_d[ST_BADCFG_BIT] | ev_bad;
    irq_d = |(stat_d & mask_d);
    if (take && avs_read)
    begin
      rdata_d = 32'h0000_0000;
      if (avs_address == OFS_MODE)
        rdata_d[15:0] = mode_q;
      else if (avs_address == OFS_COMM)
        rdata_d[15:0] = comm_q;
      else if (avs_address == OFS_DATA)
        rdata_d[15:0] = data_q;
      else if (avs_address == OFS_OUTLVL)
        rdata_d[1:0] = lvl_q;
      else if (avs_address == OFS_OUTEN)
        rdata_d[0] = oen_q;
      else if (avs_address == OFS_START)
        rdata_d[0] = go_q;
      else if (avs_address == OFS_STATUS)
        rdata_d[ST_W-1:0] = stat_q;
      else if (avs_address == OFS_MASK)
        rdata_d[ST_W-1:0] = mask_q;
      else if (avs_address == OFS_BUSY)
        rdata_d[1:0] = {scl_i, busy};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q  <= 16'h0000;
      comm_q  <= 16'h0000;
      data_q  <= RST_DATA;
      lvl_q   <= RST_LVL;
      oen_q   <= 1'b0;
      go_q    <= 1'b0;
      stat_q  <= '0;
      mask_q  <= '0;
      rdata_q <= 32'h0000_0000;
      wait_q  <= 1'b1;
      irq_q   <= 1'b0;
      pins_q  <= '0;
    end
    else
    begin
      mode_q  <= mode_d;
      comm_q  <= comm_d;
      data_q  <= data_d;
      lvl_q   <= lvl_d;
      oen_q   <= oen_d;
      go_q    <= go_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
      irq_q   <= irq_d;
      pins_q  <= pins_d;
    end
  end

  // Every output leaves a flop; the pin struct packs scl_o, scl_oe, sda_o, sda_oe in order.
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;
  assign {scl_o, scl_oe, sda_o, sda_oe} = pins_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_end_after_done: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == S_DONE) |=> stat_q[ST_END_BIT])
    else $error("transfer end not flagged");
  a_ack_err_set: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == S_DONE && ack_err_q) |=> stat_q[ST_ACKERR_BIT])
    else $error("ack error not flagged");
  a_zero_div_refused: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == S_IDLE && go_q && data_q[DIV_HI:DIV_LO] == 7'h00) |=> (st_q == S_IDLE))
    else $error("zero divisor started a frame");
  a_first_bit_msb: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == S_IDLE && st_d == S_LOW) |=> (sda_bit_q == $past(data_q[7])))
    else $error("first bit is not msb");
  a_ack_slot_free: assert property (@(posedge clk) disable iff (!reset_n)
    (bit_q == BIT_LAST && st_q != S_IDLE) |-> sda_bit_q)
    else $error("sda driven in ack slot");
  a_data_not_inverted: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == S_HIGH && oen_q) |-> (sda_oe == !sda_bit_q))
    else $error("sda drive inverted in frame");
  a_busy_div_kept: assert property (@(posedge clk) disable iff (!reset_n)
    (busy && acc && avs_write && avs_address == OFS_DATA)
      |=> (data_q[15:8] == $past(data_q[15:8])))
    else $error("divisor changed in transfer");
  a_irq_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (irq == |($past(stat_d) & $past(mask_d))))
    else $error("irq does not track status");

endmodule

// ===== core/i2c_tx_pkg.sv
// Package with register map, field positions and states of the simple I2C transmit channel.
package i2c_tx_pkg;

  // ------------------------------------------------------------------
  // Register word offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_MODE     = 4'h0; // channel_mode_reg
  localparam logic [3:0] OFS_COMM     = 4'h1; // channel_comm_setting_reg
  localparam logic [3:0] OFS_DATA     = 4'h2; // channel_data_reg
  localparam logic [3:0] OFS_OUTLVL   = 4'h3; // serial_output_level_reg
  localparam logic [3:0] OFS_OUTEN    = 4'h4; // serial_output_enable_reg
  localparam logic [3:0] OFS_START    = 4'h5; // channel_start_reg
  localparam logic [3:0] OFS_STATUS   = 4'h6; // sticky status, write one to clear
  localparam logic [3:0] OFS_MASK     = 4'h7; // interrupt mask
  localparam logic [3:0] OFS_BUSY     = 4'h8; // live state

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int MODE_CKS_BIT    = 15;  // op_clock_select_bit
  localparam int MODE_INTSEL_BIT = 0;   // 1 would select buffer-empty interrupt
  localparam int COMM_TXE_BIT    = 15;  // tx_enable_bit
  localparam int COMM_RXE_BIT    = 14;  // rx_enable_bit
  localparam int DIV_HI          = 15;
  localparam int DIV_LO          = 9;
  localparam int ST_END_BIT      = 0;   // transfer end event
  localparam int ST_ACKERR_BIT   = 1;   // ack_error_flag, parity error position
  localparam int ST_BADCFG_BIT   = 2;   // forbidden interrupt type or zero divisor
  localparam int ST_W            = 3;
  localparam int FRAME_BITS      = 9;   // eight data bits plus acknowledge slot

  localparam logic [15:0] RST_DATA  = 16'h0200; // divisor one after reset
  localparam logic [1:0]  RST_LVL   = 2'h3;     // SCL and SDA idle high
  localparam logic [6:0]  DIV_MIN   = 7'h01;
  localparam logic [3:0]  BIT_LAST  = 4'h8;

  // Prescaler terminal counts for the two operation clocks; a tick comes every count plus one clk cycles.
  localparam logic [7:0] PRE0_DIV = 8'h01;
  localparam logic [7:0] PRE1_DIV = 8'h04;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_LOW  = 4'b0010,
    S_HIGH = 4'b0100,
    S_DONE = 4'b1000
  } tx_state_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2c_pins_t;

endpackage

// ===== verification/i2c_slave_model.sv
// Behavioural I2C slave that shifts in each frame and acknowledges on request.
module i2c_slave_model (
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  ack_en,
  output logic       sda_pull,
  output logic [7:0] last_byte,
  output int         nbytes
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] shift_q;
  int         bit_cnt;

  // Idle with the data line released so the pull-up sets its level.
  initial
  begin
    sda_pull  = 1'b0;
    last_byte = 8'h00;
    nbytes    = 0;
    bit_cnt   = 0;
    shift_q   = 8'h00;
  end

  // A falling data line while the clock is high marks a new frame.
  // The check is repeated a moment later so a clock fall in the same instant is not a start.
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      #1;
      if (scl === 1'b1)
        bit_cnt = 0;
    end

  // Bits arrive most significant first; the ninth rising edge only ends the frame.
  always @(posedge scl)
    if (bit_cnt < 8)
    begin
      shift_q = {shift_q[6:0], sda};
      bit_cnt++;
      if (bit_cnt == 8)
      begin
        last_byte = shift_q;
        nbytes++;
      end
    end
    else
      bit_cnt = 0;

  // Hold the line low over the whole ninth clock when told to acknowledge.
  always @(negedge scl)
    sda_pull = ack_en && (bit_cnt == 8);
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the I2C transmit channel against a slave model.
module testbench;
  import i2c_tx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        scl_o, scl_oe, sda_o, sda_oe, irq, ack_en, sda_pull;
  logic [7:0]  last_byte, b;
  logic [7:0]  exp_q[$];
  wire         scl_line, sda_line;
  int          nbytes, fails, compares, cycles, hi_run, hi_len, sent;

  // Open-drain lines with pull-ups: released means high.
  assign scl_line = scl_oe ? scl_o : 1'b1;
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

  i2c_tx_channel i2c_tx_channel_inst (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
  );

  i2c_slave_model i2c_slave_model_inst (
    .scl(scl_line), .sda(sda_line), .ack_en(ack_en), .sda_pull(sda_pull),
    .last_byte(last_byte), .nbytes(nbytes)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Width of the first clock-high phase after hi_len is cleared, in system clock cycles.
  always @(posedge clk)
    if (scl_line === 1'b1)
      hi_run <= hi_run + 1;
    else
    begin
      if (hi_run > 0 && hi_len == 0)
        hi_len <= hi_run;
      hi_run <= 0;
    end

  // A hang ends the run as a failure rather than stalling forever.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd_q);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd_q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100)
      chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] rd_q);
    bus(1'b0, a, 32'h0, rd_q);
  endtask

  // Software start sequence, one frame, then result, divisor and interrupt checks.
  task automatic frame(input logic cks, input logic [6:0] dv, input logic [7:0] byt,
                       input logic ack);
    logic [31:0] r;
    int          n;
    int          pre;
    ack_en <= ack;
    wr(OFS_MODE, {16'h0, cks, 15'h0});
    wr(OFS_OUTEN, 32'h0);
    wr(OFS_OUTLVL, 32'h3);
    wr(OFS_OUTLVL, 32'h2);
    wr(OFS_OUTLVL, 32'h0);
    wr(OFS_OUTEN, 32'h1);
    hi_len = 0;
    wr(OFS_DATA, {16'h0, dv, 1'b0, byt});
    exp_q.push_back(byt);
    sent++;
    wr(OFS_START, 32'h1);
    // Only the low byte may change mid-frame; this write also tries divisor 7f and bit 8, which must be kept.
    wr(OFS_DATA, {16'h0, 7'h7f, 1'b1, byt});
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 3000)
    begin
      rd(OFS_BUSY, r);
      n++;
    end
    chk("busy", 32'h0, {31'h0, r[0]});
    chk("drive_low", 32'h0, {30'h0, scl_o, sda_o});
    rd(OFS_STATUS, r);
    chk("status", 32'(1 << ST_END_BIT) | (ack ? 32'h0 : 32'(1 << ST_ACKERR_BIT)), r);
    chk("slave_byte", {24'h0, exp_q.pop_front()}, {24'h0, last_byte});
    chk("slave_count", 32'(sent), 32'(nbytes));
    pre = int'(cks ? PRE1_DIV : PRE0_DIV) + 1;
    chk("scl_high", 32'((int'(dv) + 1) * pre), 32'(hi_len));
    rd(OFS_DATA, r);
    chk("divisor", {25'h0, dv}, {25'h0, r[DIV_HI:DIV_LO]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 32'h7);
    rd(OFS_STATUS, r);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(OFS_STATUS, 32'h7);
    rd(OFS_STATUS, r);
    chk("status_clr", 32'h0, r);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 32'h0);
  endtask

  initial
  begin
    reset_n       = 1'b0;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    ack_en        = 1'b1;
    fails = 0;
    compares = 0;
    cycles = 0;
    hi_run = 0;
    hi_len = 0;
    sent = 0;
    void'($urandom(32'h0b3e));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, idle lines and an unmapped place.
    chk("idle_lines", 32'h3, {30'h0, scl_line, sda_line});
    rd(OFS_DATA, q);
    chk("data_rst", {16'h0, RST_DATA}, q);
    rd(OFS_STATUS, q);
    chk("status_rst", 32'h0, q);
    wr(4'hf, 32'hffff);
    rd(4'hf, q);
    chk("unmapped", 32'h0, q);
    // Each byte goes as its own frame after a fresh start; one nack, both clock selects.
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom);
      // Divisors keep the bit rate at or below the 1 MHz fast mode plus limit.
      frame(i[0], 7'(24 + 8 * i), b, i != 2);
    end
    // Zero divisor and the forbidden interrupt type must both refuse a frame.
    for (int j = 0; j < 2; j++)
    begin
      wr(OFS_MODE, j ? 32'(1 << MODE_INTSEL_BIT) : 32'h0);
      wr(OFS_DATA, j ? {16'h0, DIV_MIN, 9'h0a5} : 32'h00a5);
      wr(OFS_START, 32'h1);
      rd(OFS_BUSY, q);
      chk("refused_idle", 32'h0, {31'h0, q[0]});
      rd(OFS_STATUS, q);
      chk("badcfg", 32'(1 << ST_BADCFG_BIT), q);
      chk("no_frame", 32'(sent), 32'(nbytes));
      wr(OFS_STATUS, 32'h7);
    end
    end_of_test();
  end
endmodule
